// File: core/kse_defines.vh
// constants for the keypad scan encoder
`ifndef KSE_DEFINES_VH
`define KSE_DEFINES_VH
`define KSE_CLK_HZ 200000000
`define KSE_SCAN_HZ 800
`define KSE_TICK_CYC (`KSE_CLK_HZ / `KSE_SCAN_HZ)
`define KSE_ROWS 4
`define KSE_COLS 4
`define KSE_STEP_KEY 5'h10
`define KSE_NO_KEY 5'h1f
`define KSE_RESET_CODE 4'h0
`define KSE_MUTE_PRE_TICKS 8'h50
`define KSE_MUTE_LEN_TICKS 8'hf0
`define KSE_PWR_MUTE_TICKS 8'hf0
`endif

// File: core/kse_sync.v
// two-flop synchroniser for pin inputs
`default_nettype none
module kse_sync #(
  parameter W = 6
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q;
  always @(posedge clk) begin
    if (rst) begin
      meta_q <= {W{1'b1}};
      q <= {W{1'b1}};
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // kse_sync
`default_nettype wire

// File: core/kse_keypad_encoder.v
// keypad scan encoder: row scan, debounce, interlock, code latch and mute
`include "kse_defines.vh"
`default_nettype none
module kse_keypad_encoder #(
  parameter TICK_CYC = `KSE_TICK_CYC,
  parameter [7:0] MUTE_PRE = `KSE_MUTE_PRE_TICKS,
  parameter [7:0] MUTE_LEN = `KSE_MUTE_LEN_TICKS,
  parameter [7:0] PWR_MUTE = `KSE_PWR_MUTE_TICKS
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [3:0] col_n,
  input wire step_n,
  input wire lock_n,
  output reg [3:0] row_oe,
  output wire [3:0] row_o,
  output reg code_bit0,
  output reg code_bit1,
  output reg code_bit2,
  output reg code_bit3,
  output reg mute
);
  // open-drain rows: output value always low, enable selects the row
  assign row_o = 4'h0;

  wire [5:0] pins_s;
  kse_sync #(.W(6)) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d({lock_n, step_n, col_n}),
    .q(pins_s)
  );
  wire [3:0] col_s = pins_s[3:0];
  wire step_s = pins_s[4];
  wire lock_s = pins_s[5];

  function [3:0] bit_count;
    input [3:0] v;
    begin
      bit_count = {3'h0, v[0]} + {3'h0, v[1]} + {3'h0, v[2]} + {3'h0, v[3]};
    end
  endfunction

  // scan tick divider, the only time base
  reg [31:0] div_q;
  wire tick = (div_q == TICK_CYC - 1);
  always @(posedge clk) begin
    if (rst) div_q <= 32'h0;
    else if (ce) div_q <= tick ? 32'h0 : div_q + 32'h1;
  end

  // slot 0..3 rows, slot 4 samples step input
  reg [2:0] slot_q;
  reg [3:0] hold_q;
  reg multi_q;
  reg [4:0] found_q;
  reg [4:0] pend_q;
  reg [4:0] key_q;
  reg [3:0] sel_q;
  reg [3:0] new_q;
  reg [7:0] mcnt_q;
  reg [1:0] mst_q;
  localparam [1:0] M_IDLE = 2'h0;
  localparam [1:0] M_PRE = 2'h1;
  localparam [1:0] M_POST = 2'h2;
  localparam [1:0] M_PWR = 2'h3;

  always @(posedge clk) begin
    if (rst) begin
      row_oe <= 4'h0;
    end else if (ce) begin
      row_oe <= (slot_q < 3'h4) ? (4'h1 << slot_q[1:0]) : 4'h0;
    end
  end

  wire [3:0] col_hit = ~col_s;
  wire slot_end = tick;
  wire busy = (mst_q != M_IDLE);
  // step is a level key in slot 4, so a held step repeats after each mute
  wire step_hit = hold_q[0] & ~step_s;
  wire [4:0] cand = step_hit ? `KSE_STEP_KEY : found_q;

  always @(posedge clk) begin
    if (rst) begin
      slot_q <= 3'h0;
      hold_q <= 4'hf;
      multi_q <= 1'b0;
      found_q <= `KSE_NO_KEY;
      pend_q <= `KSE_NO_KEY;
      key_q <= `KSE_NO_KEY;
    end else if (ce) begin
      key_q <= `KSE_NO_KEY;
      // column must stay low for the whole row pulse
      // first three clocks of a slot still show the previous row (oe flop plus sync)
      if (slot_end) hold_q <= 4'hf;
      else if (div_q > 32'h2) hold_q <= hold_q & ((slot_q < 3'h4) ? col_hit : {3'h0, ~step_s});
      if (slot_end) begin
        if (slot_q < 3'h4) begin
          if (bit_count(hold_q & col_hit) > 4'h1) begin
            multi_q <= 1'b1;
          end else if (bit_count(hold_q & col_hit) == 4'h1) begin
            if (found_q != `KSE_NO_KEY) multi_q <= 1'b1;
            else found_q <= {1'b0, slot_q[1:0],
              (hold_q[2] & col_hit[2]) | (hold_q[3] & col_hit[3]),
              (hold_q[1] & col_hit[1]) | (hold_q[3] & col_hit[3])};
          end
          slot_q <= slot_q + 3'h1;
        end else begin
          // scan cycle end: confirm against pending
          slot_q <= 3'h0;
          found_q <= `KSE_NO_KEY;
          multi_q <= 1'b0;
          if (multi_q || busy || (step_hit && found_q != `KSE_NO_KEY)) begin
            pend_q <= `KSE_NO_KEY;
          end else if (cand != `KSE_NO_KEY && cand == pend_q) begin
            key_q <= cand;
            pend_q <= `KSE_NO_KEY;
          end else begin
            pend_q <= cand;
          end
        end
      end
    end
  end

  // mute sequencer and code latch
  always @(posedge clk) begin
    if (rst) begin
      mst_q <= M_PWR;
      mcnt_q <= PWR_MUTE;
      sel_q <= `KSE_RESET_CODE;
      new_q <= `KSE_RESET_CODE;
      mute <= 1'b1;
      {code_bit3, code_bit2, code_bit1, code_bit0} <= `KSE_RESET_CODE;
    end else if (ce) begin
      case (mst_q)
        M_IDLE: begin
          mute <= 1'b0;
          if (key_q != `KSE_NO_KEY && lock_s) begin
            new_q <= (key_q == `KSE_STEP_KEY) ? sel_q + 4'h1 : key_q[3:0];
            mst_q <= M_PRE;
            mcnt_q <= MUTE_PRE;
            mute <= 1'b1;
          end
        end
        M_PRE: begin
          if (tick) begin
            if (mcnt_q == 8'h0) begin
              sel_q <= new_q;
              {code_bit3, code_bit2, code_bit1, code_bit0} <= new_q;
              mst_q <= M_POST;
              mcnt_q <= MUTE_LEN;
            end else mcnt_q <= mcnt_q - 8'h1;
          end
        end
        M_POST, M_PWR: begin
          if (tick) begin
            if (mcnt_q == 8'h0) begin
              mst_q <= M_IDLE;
              mute <= 1'b0;
            end else mcnt_q <= mcnt_q - 8'h1;
          end
        end
        default: mst_q <= M_IDLE;
      endcase
    end
  end
endmodule // kse_keypad_encoder
`default_nettype wire

// File: dv/kse_monitor.sv
// port checker for the keypad scan encoder
`default_nettype none
module kse_monitor #(parameter TICK_CYC=8,MUTE_PRE=2,MUTE_LEN=2,PWR_MUTE=2) (
  input wire logic clk,rst,ce,step_n,lock_n,mute,code_bit0,code_bit1,code_bit2,code_bit3,
  input wire logic [3:0] col_n,row_oe,row_o
);
  wire [3:0] c={code_bit3,code_bit2,code_bit1,code_bit0};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_hold; $stable(c)[*8]; endsequence
  property p_rst; disable iff (1'b0) rst |=> c==4'h0 && mute && row_oe==4'h0; endproperty
  a_rst: assert property(p_rst) else $error("reset");
  property p_pwr; $fell(rst) |-> mute[*8]; endproperty
  a_pwr: assert property(p_pwr) else $error("pwr");
  property p_row; $onehot0(row_oe) && row_o==4'h0; endproperty
  a_row: assert property(p_row) else $error("row");
  property p_chg; !$stable(c) |-> mute; endproperty
  a_chg: assert property(p_chg) else $error("code");
  property p_mute; $rose(mute) |-> mute[*8]; endproperty
  a_mute: assert property(p_mute) else $error("mute");
  property p_late; $rose(mute) |=> s_hold; endproperty
  a_late: assert property(p_late) else $error("late");
  property p_lock; (!lock_n)[*4] |=> !$rose(mute); endproperty
  a_lock: assert property(p_lock) else $error("lock");
  // row slots only move on scan ticks, eight clocks apart here
  property p_tick; !$stable(row_oe) |=> $stable(row_oe)[*7]; endproperty
  a_tick: assert property(p_tick) else $error("tick");
endmodule // kse_monitor
bind kse_keypad_encoder kse_monitor #(.TICK_CYC(TICK_CYC),.MUTE_PRE(MUTE_PRE),.MUTE_LEN(MUTE_LEN),
  .PWR_MUTE(PWR_MUTE)) kse_monitor_i(.*);
`default_nettype wire

// File: dv/kse_keys.sv
// key matrix model
`default_nettype none
module kse_keys (
  input wire logic [3:0] row_oe,
  input wire logic [15:0] km,
  output logic [3:0] col_n
);
  // open columns sit high on their pull-ups
  always_comb for(int c=0;c<4;c++) col_n[c]=~|(row_oe&{km[12+c],km[8+c],km[4+c],km[c]});
endmodule // kse_keys
`default_nettype wire

// File: dv/kse_keypad_encoder_tb_top.sv
// bench for the keypad scan encoder
`default_nettype none
module kse_keypad_encoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk=0,rst=1,step_n=1,lock_n=1;
  logic [15:0] km=0;
  wire [3:0] col_n,row_oe,row_o;
  wire b0,b1,b2,b3,mute;
  wire [3:0] code={b3,b2,b1,b0};
  int n_mismatch=0,n_compared=0,cyc=0;
  always #2.5 clk=~clk;
  kse_keypad_encoder #(.TICK_CYC(8),.MUTE_PRE(2),.MUTE_LEN(2),.PWR_MUTE(2)) kse_keypad_encoder_i(.clk(clk),
    .rst(rst),.ce(1'b1),.col_n(col_n),.step_n(step_n),.lock_n(lock_n),.row_oe(row_oe),.row_o(row_o),
    .code_bit0(b0),.code_bit1(b1),.code_bit2(b2),.code_bit3(b3),.mute(mute));
  kse_keys kse_keys_i(.row_oe(row_oe),.km(km),.col_n(col_n));
  task chk(string n,logic [3:0] s,e);
    n_compared++;
    if(s!==e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h",n,e,s);
    end
  endtask
  task stop_test;
    $display("compared %0d mismatched %0d",n_compared,n_mismatch);
    if(n_mismatch==0&&n_compared>0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task wt(logic v);
    for(int i=0;i<200&&mute!==v;i++) @(negedge clk);
  endtask
  // hold until mute ends, then two clean scans before the next press
  task press(logic [15:0] m,logic s,a,logic [3:0] e);
    @(negedge clk);
    km=m;
    step_n=!s;
    wt(1);
    chk("mute",{3'h0,mute},{3'h0,a});
    wt(0);
    km=0;
    step_n=1;
    repeat(100) @(negedge clk);
    chk("code",code,e);
  endtask
  task t_reset;
    chk("code",code,4'h0);
    chk("mute",{3'h0,mute},4'h1);
    wt(0);
    $display("t_reset done");
  endtask
  task t_keys;
    for(int k=0;k<16;k++) press(16'h1<<k,0,1,k[3:0]);
    $display("t_keys done");
  endtask
  task t_multi;
    press(16'h0005,0,0,4'hf);
    press(16'h0001,1,0,4'hf);
    $display("t_multi done");
  endtask
  task t_lock;
    lock_n=0;
    press(16'h0002,0,0,4'hf);
    press(16'h0000,1,0,4'hf);
    lock_n=1;
    $display("t_lock done");
  endtask
  task t_step;
    press(16'h0000,1,1,4'h0);
    press(16'h0000,1,1,4'h1);
    $display("t_step done");
  endtask
  initial begin
    repeat(5) @(negedge clk);
    rst=0;
    t_reset;
    t_keys;
    t_multi;
    t_lock;
    t_step;
    stop_test;
  end
  always @(posedge clk) begin
    cyc<=cyc+1;
    if(cyc==30000) begin
      n_mismatch++;
      stop_test;
    end
  end
endmodule // kse_keypad_encoder_tb_top
`default_nettype wire
